//--- logic/seq_device.sv
// Control write sequencer with step memory and control register bank.
// Assumes the host drives ctrl_if on the same hclk.
`default_nettype none
module seq_device #(
  parameter int TICK_LEN = seq_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control interface
  ctrl_if.dev bus,
  // Control register 1 view and sequencer status
  output logic [15:0] ctl_reg0_view,
  output logic seq_busy,
  output logic sequence_done_event
);
  logic [15:0] tgt_mem [0:seq_pkg::RAM_STEPS-1];
  logic [15:0] pay_mem [0:seq_pkg::RAM_STEPS-1];
  logic [15:0] ctl_reg [0:seq_pkg::CTL_DEPTH-1];
  logic [4:0] step_write_pointer_reg;
  logic [5:0] launch_index_reg, current_step_index_reg;
  logic launch_bit_reg, event_reg, rd_ack_reg;
  seq_pkg::seq_state_t state_reg;
  logic [15:0] cur_tgt_reg, cur_pay_reg, cyc_cnt_reg, tick_cnt_reg;
  logic [15:0] rdata_reg;
  logic host_wr, sw_reset, launch_req, abort_req, busy;
  logic [15:0] step_tgt, step_pay;
  logic [2:0] step_field_width;
  logic [3:0] step_field_start;
  logic [7:0] step_register_address;
  logic [3:0] step_delay_code;
  logic end_of_sequence_bit;
  logic [7:0] low_mask;
  logic [15:0] ticks_needed, field_mask, field_bits;
  logic tick_end, step_done;

  // Registers the sequencer may touch and the host may store to while idle
  function automatic logic plain_reg(input logic [7:0] a);
    plain_reg = (a < 8'(seq_pkg::CTL_DEPTH)) && (a != seq_pkg::REG_SW_RESET)
      && !(a >= seq_pkg::REG_WRITE_PTR && a <= seq_pkg::REG_STATUS)
      && (a != seq_pkg::REG_EVENT);
  endfunction : plain_reg

  // Fixed shutdown table: dummy steps, every step from ROM_LAST up ends the sequence
  function automatic logic [31:0] rom_step(input logic [5:0] idx);
    logic [15:0] pay;
    pay = 16'h0000;
    if (idx >= seq_pkg::ROM_LAST) begin
      pay[seq_pkg::EOS_BIT] = 1'b1;
    end
    rom_step = {8'h00, seq_pkg::DUMMY_ADDR, pay};
  endfunction : rom_step

  assign busy = (state_reg != seq_pkg::S_IDLE);
  assign host_wr = bus.wr_stb;
  assign sw_reset = host_wr && (bus.addr == seq_pkg::REG_SW_RESET);
  assign launch_req = host_wr && (bus.addr == seq_pkg::REG_LAUNCH)
    && bus.wdata[seq_pkg::LAUNCH_BIT];
  assign abort_req = host_wr && (bus.addr == seq_pkg::REG_LAUNCH)
    && bus.wdata[seq_pkg::ABORT_BIT];

  // Step fields of the step being executed
  assign step_field_width = cur_tgt_reg[seq_pkg::WIDTH_LSB +: 3];
  assign step_field_start = cur_tgt_reg[seq_pkg::START_LSB +: 4];
  assign step_register_address = cur_tgt_reg[7:0];
  assign step_delay_code = cur_pay_reg[seq_pkg::DELAY_LSB +: 4];
  assign end_of_sequence_bit = cur_pay_reg[seq_pkg::EOS_BIT];
  assign low_mask = 8'hff >> (3'h7 - step_field_width);
  assign field_mask = {8'h00, low_mask} << step_field_start;
  assign field_bits = {8'h00, cur_pay_reg[7:0] & low_mask}
    << step_field_start;
  assign ticks_needed = (16'h0001 << step_delay_code)
    + seq_pkg::DELAY_BASE;
  assign tick_end = (cyc_cnt_reg == 16'(TICK_LEN - 1));
  assign step_done = tick_end && (tick_cnt_reg == ticks_needed - 16'h0001);

  // Next step source: RAM below 32, ROM above
  always_comb begin
    if (current_step_index_reg < 6'(seq_pkg::RAM_STEPS)) begin
      step_tgt = tgt_mem[current_step_index_reg[4:0]];
      step_pay = pay_mem[current_step_index_reg[4:0]];
    end else begin
      {step_tgt, step_pay} = rom_step(current_step_index_reg);
    end
  end

  // Step RAM: power-up defaults only, untouched by software reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < seq_pkg::RAM_STEPS; i++) begin
        tgt_mem[i] <= {8'h00, seq_pkg::DUMMY_ADDR};
        pay_mem[i] <= (i == int'(seq_pkg::DEFAULT_LAST)) ? 16'h4000
          : 16'h0000;
      end
    end else if (host_wr && bus.addr == seq_pkg::REG_TARGET) begin
      tgt_mem[step_write_pointer_reg] <= {1'b0, bus.wdata[14:0]};
    end else if (host_wr && bus.addr == seq_pkg::REG_PAYLOAD) begin
      pay_mem[step_write_pointer_reg] <= bus.wdata;
    end
  end

  // Write pointer; five bits cannot reach ROM
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      step_write_pointer_reg <= 5'h00;
    end else if (sw_reset) begin
      step_write_pointer_reg <= 5'h00;
    end else if (host_wr && bus.addr == seq_pkg::REG_WRITE_PTR) begin
      step_write_pointer_reg <= bus.wdata[4:0];
    end
  end

  // Control register bank
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < seq_pkg::CTL_DEPTH; i++) begin
        ctl_reg[i] <= 16'h0000;
      end
    end else if (sw_reset) begin
      for (int i = 0; i < seq_pkg::CTL_DEPTH; i++) begin
        ctl_reg[i] <= 16'h0000;
      end
    end else if (state_reg == seq_pkg::S_EXEC
                 && plain_reg(step_register_address)) begin
      ctl_reg[step_register_address[6:0]] <=
        (ctl_reg[step_register_address[6:0]] & ~field_mask)
        | field_bits;
    end else if (host_wr && !busy && plain_reg(bus.addr)) begin
      ctl_reg[bus.addr[6:0]] <= bus.wdata;
    end
  end

  // Launch register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      launch_index_reg <= 6'h00;
      launch_bit_reg <= 1'b0;
    end else if (sw_reset || abort_req) begin
      launch_bit_reg <= 1'b0;
    end else if (launch_req && !busy) begin
      launch_index_reg <= bus.wdata[5:0];
      launch_bit_reg <= 1'b1;
    end else if (state_reg == seq_pkg::S_WAIT && step_done
                 && end_of_sequence_bit) begin
      launch_bit_reg <= 1'b0;
    end
  end

  // Sequencer state and current index
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= seq_pkg::S_IDLE;
      current_step_index_reg <= 6'h00;
      cur_tgt_reg <= 16'h0000;
      cur_pay_reg <= 16'h0000;
    end else if (sw_reset || abort_req) begin
      state_reg <= seq_pkg::S_IDLE;
    end else begin
      case (state_reg)
        seq_pkg::S_IDLE: begin
          if (launch_req) begin
            current_step_index_reg <= bus.wdata[5:0];
            state_reg <= seq_pkg::S_FETCH;
          end
        end
        seq_pkg::S_FETCH: begin
          cur_tgt_reg <= step_tgt;
          cur_pay_reg <= step_pay;
          state_reg <= seq_pkg::S_EXEC;
        end
        seq_pkg::S_EXEC: begin
          state_reg <= seq_pkg::S_WAIT;
        end
        seq_pkg::S_WAIT: begin
          if (step_done) begin
            if (end_of_sequence_bit) begin
              state_reg <= seq_pkg::S_IDLE;
            end else begin
              current_step_index_reg <= current_step_index_reg + 6'h01;
              state_reg <= seq_pkg::S_FETCH;
            end
          end
        end
        default: begin
          state_reg <= seq_pkg::S_IDLE;
        end
      endcase
    end
  end

  // Step timer, restarted at every fetch so steps are exact
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cyc_cnt_reg <= 16'h0000;
      tick_cnt_reg <= 16'h0000;
    end else if (state_reg == seq_pkg::S_FETCH
                 || state_reg == seq_pkg::S_IDLE) begin
      cyc_cnt_reg <= 16'h0001;
      tick_cnt_reg <= 16'h0000;
    end else if (tick_end) begin
      cyc_cnt_reg <= 16'h0000;
      tick_cnt_reg <= tick_cnt_reg + 16'h0001;
    end else begin
      cyc_cnt_reg <= cyc_cnt_reg + 16'h0001;
    end
  end

  // Done event: set wins over write-one clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      event_reg <= 1'b0;
    end else if (state_reg == seq_pkg::S_WAIT && step_done
                 && end_of_sequence_bit && !abort_req && !sw_reset) begin
      event_reg <= 1'b1;
    end else if (host_wr && bus.addr == seq_pkg::REG_EVENT
                 && bus.wdata[0]) begin
      event_reg <= 1'b0;
    end
  end

  // Read port; ordinary registers read zero while busy
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_reg <= 16'h0000;
      rd_ack_reg <= 1'b0;
    end else begin
      rd_ack_reg <= bus.rd_stb;
      case (bus.addr)
        seq_pkg::REG_WRITE_PTR: rdata_reg <= {11'h000, step_write_pointer_reg};
        seq_pkg::REG_TARGET: rdata_reg <= tgt_mem[step_write_pointer_reg];
        seq_pkg::REG_PAYLOAD: rdata_reg <= pay_mem[step_write_pointer_reg];
        seq_pkg::REG_LAUNCH: rdata_reg <= {7'h00, launch_bit_reg, 2'h0,
                                           launch_index_reg};
        seq_pkg::REG_STATUS: rdata_reg <= {6'h00, current_step_index_reg,
                                           3'h0, busy};
        seq_pkg::REG_EVENT: rdata_reg <= {15'h0000, event_reg};
        default: begin
          rdata_reg <= (plain_reg(bus.addr) && !busy)
            ? ctl_reg[bus.addr[6:0]] : 16'h0000;
        end
      endcase
    end
  end

  assign bus.rdata = rdata_reg;
  assign bus.rd_ack = rd_ack_reg;
  assign bus.busy = busy;
  assign seq_busy = busy;
  assign sequence_done_event = event_reg;
  assign ctl_reg0_view = ctl_reg[1];
endmodule : seq_device
`default_nettype wire

//--- logic/seq_pkg.sv
// Shared constants and types for the control write sequencer and its host.
// Assumes one 100 MHz clock shared by both ends.
`default_nettype none
package seq_pkg;
  // Device register addresses on the control interface
  localparam logic [7:0] REG_SW_RESET = 8'h00;
  localparam logic [7:0] REG_WRITE_PTR = 8'h6c;
  localparam logic [7:0] REG_TARGET = 8'h6d;
  localparam logic [7:0] REG_PAYLOAD = 8'h6e;
  localparam logic [7:0] REG_LAUNCH = 8'h6f;
  localparam logic [7:0] REG_STATUS = 8'h70;
  localparam logic [7:0] REG_EVENT = 8'h79;
  localparam logic [7:0] DUMMY_ADDR = 8'hff;
  // Field positions
  localparam int WIDTH_LSB = 12;
  localparam int START_LSB = 8;
  localparam int EOS_BIT = 14;
  localparam int DELAY_LSB = 8;
  localparam int LAUNCH_BIT = 8;
  localparam int ABORT_BIT = 9;
  localparam int CUR_LSB = 4;
  localparam int BUSY_BIT = 0;
  // Step memory layout
  localparam int RAM_STEPS = 32;
  localparam logic [5:0] ROM_LAST = 6'h30;
  localparam logic [5:0] DEFAULT_LAST = 6'h1d;
  localparam int CTL_DEPTH = 128;
  // Step timing
  localparam int TICK_NS = 62500;
  localparam int CLK_NS = 10;
  localparam int TICK_CYCLES = TICK_NS / CLK_NS;
  localparam logic [15:0] DELAY_BASE = 16'h0008;
  // Launch words for the default sequences
  localparam logic [15:0] LAUNCH_STARTUP = 16'h0100;
  localparam logic [15:0] LAUNCH_SHUTDOWN = 16'h0120;
  // Host AHB register offsets
  localparam logic [7:0] H_ADDR = 8'h00;
  localparam logic [7:0] H_WDATA = 8'h04;
  localparam logic [7:0] H_READ = 8'h08;
  localparam logic [7:0] H_RDATA = 8'h0c;
  localparam logic [7:0] H_STATUS = 8'h10;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  typedef enum logic [1:0] {S_IDLE, S_FETCH, S_EXEC, S_WAIT} seq_state_t;
endpackage : seq_pkg
`default_nettype wire

//--- logic/ctrl_if.sv
// Control interface between host controller and sequencer device.
// Single clock; strobes are one-cycle pulses.
`default_nettype none
interface ctrl_if;
  logic wr_stb;
  logic rd_stb;
  logic [7:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic rd_ack;
  logic busy;
  modport dev (input wr_stb, rd_stb, addr, wdata,
               output rdata, rd_ack, busy);
  modport ctl (output wr_stb, rd_stb, addr, wdata,
               input rdata, rd_ack, busy);
endinterface : ctrl_if
`default_nettype wire

//--- logic/seq_host.sv
// Host controller: AHB-Lite slave that forwards register orders to ctrl_if.
// Assumes a single AHB master and the device on the same hclk.
`default_nettype none
module seq_host (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Device side
  ctrl_if.ctl dev
);
  logic ph_wr_reg;
  logic [7:0] ph_addr_reg;
  logic [7:0] dev_addr_reg;
  logic [15:0] dev_wdata_reg;
  logic [15:0] rd_result_reg;
  logic wr_stb_reg;
  logic rd_stb_reg;
  logic read_done_reg;
  logic refused_reg;
  logic [31:0] hrdata_reg;
  logic take;
  logic wr_data;
  logic seq_side;

  assign take = hsel && hready && htrans == seq_pkg::HTRANS_NONSEQ;
  assign wr_data = ph_wr_reg && ph_addr_reg == seq_pkg::H_WDATA;
  // Sequencer and reset registers stay open while busy
  assign seq_side = dev_addr_reg == seq_pkg::REG_SW_RESET
    || dev_addr_reg == seq_pkg::REG_EVENT
    || (dev_addr_reg >= seq_pkg::REG_WRITE_PTR
        && dev_addr_reg <= seq_pkg::REG_STATUS);

  // Address phase capture; hsize is always a word here
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr_reg <= 1'b0;
      ph_addr_reg <= 8'h00;
    end else begin
      ph_wr_reg <= take && hwrite;
      ph_addr_reg <= haddr[7:0];
    end
  end

  // Read data prepared in the address phase, so no wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      case (haddr[7:0])
        seq_pkg::H_ADDR: hrdata_reg <= {24'h000000, dev_addr_reg};
        seq_pkg::H_WDATA: hrdata_reg <= {16'h0000, dev_wdata_reg};
        seq_pkg::H_RDATA: hrdata_reg <= {16'h0000, rd_result_reg};
        seq_pkg::H_STATUS: hrdata_reg <= {29'h00000000, dev.busy,
                                          refused_reg, read_done_reg};
        default: hrdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  // Host-held address and data; payload passes as given
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dev_addr_reg <= 8'h00;
      dev_wdata_reg <= 16'h0000;
    end else if (ph_wr_reg && ph_addr_reg == seq_pkg::H_ADDR) begin
      dev_addr_reg <= hwdata[7:0];
    end else if (wr_data) begin
      dev_wdata_reg <= hwdata[15:0];
    end
  end

  // Strobes follow the data phase by one cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_stb_reg <= 1'b0;
      rd_stb_reg <= 1'b0;
    end else begin
      wr_stb_reg <= wr_data && (seq_side || !dev.busy);
      rd_stb_reg <= ph_wr_reg && ph_addr_reg == seq_pkg::H_READ;
    end
  end

  // Status flags; a new set wins over the clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      read_done_reg <= 1'b0;
      refused_reg <= 1'b0;
      rd_result_reg <= 16'h0000;
    end else begin
      if (dev.rd_ack) begin
        read_done_reg <= 1'b1;
        rd_result_reg <= dev.rdata;
      end else if (rd_stb_reg) begin
        read_done_reg <= 1'b0;
      end
      if (wr_data && !seq_side && dev.busy) begin
        refused_reg <= 1'b1;
      end else if (ph_wr_reg && ph_addr_reg == seq_pkg::H_STATUS
                   && hwdata[1]) begin
        refused_reg <= 1'b0;
      end
    end
  end

  assign dev.wr_stb = wr_stb_reg;
  assign dev.rd_stb = rd_stb_reg;
  assign dev.addr = dev_addr_reg;
  assign dev.wdata = dev_wdata_reg;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;
endmodule : seq_host
`default_nettype wire

//--- verification/seq_props.sv
// Checker for the host-to-sequencer control link.
// Assumes one hclk domain; link signals come in as plain inputs.
`default_nettype none
module seq_props #(
  parameter int TICK_LEN = 4
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Link signals
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic rd_ack,
  input wire logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [19:0] run_reg;
  logic lch, go, stop, plain;
  assign lch = wr_stb && addr == seq_pkg::REG_LAUNCH;
  assign go = lch && wdata[8];
  assign stop = wr_stb && (addr == 8'h00 || (lch && wdata[9]));
  // Sequencer registers stay reachable, so only low bank counts
  assign plain = addr > 8'h00 && addr < 8'h6c;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_reg <= 20'h0;
    end else begin
      run_reg <= busy ? run_reg + 20'h1 : 20'h0;
    end
  end
  ack_follows_a: assert property (rd_stb |=> rd_ack)
    else $error("read strobe got no ack");
  ack_cause_a: assert property (rd_ack |-> $past(rd_stb))
    else $error("ack without read strobe");
  launch_busy_a: assert property (
    go && !wdata[9] && !busy |=> busy)
    else $error("launch did not start sequencer");
  rise_cause_a: assert property ($rose(busy) |-> $past(go))
    else $error("busy rose without launch");
  abort_halt_a: assert property (
    lch && wdata[9] && !wdata[8] |=> !busy)
    else $error("abort left sequencer busy");
  soft_stop_a: assert property (
    wr_stb && addr == 8'h00 |=> !busy)
    else $error("software reset left sequencer busy");
  step_time_a: assert property (
    $fell(busy) && !$past(stop) |-> run_reg >= 9 * TICK_LEN - 1)
    else $error("sequence shorter than one step");
  locked_read_a: assert property (
    rd_stb && busy && plain |=> rdata == 16'h0000)
    else $error("locked register read not zero");
  locked_write_a: assert property (
    wr_stb && $past(busy) |-> !plain)
    else $error("locked register written while busy");
endmodule : seq_props
`default_nettype wire

//--- verification/tb.sv
// Self-checking bench: AHB master drives the host, host drives the device.
// Assumes TICK_LEN cut to 4 cycles so step times stay short.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TL = 4;
  logic hclk, hresetn, hsel, hwrite, hready, hresp, seq_busy, done_ev;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] reg1_view;
  int errors, tests_run;
  logic [15:0] tg [4] = '{16'h0001, 16'h7801, 16'h1101, 16'h1e01};
  logic [15:0] od [4] = '{16'hffff, 16'h0000, 16'h0000, 16'h5555};
  logic [7:0] dt [4] = '{8'hfe, 8'ha5, 8'hff, 8'h02};
  ctrl_if u_ctrl_if ();
  seq_host u_seq_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
    .hrdata(hrdata), .dev(u_ctrl_if.ctl));
  seq_device #(.TICK_LEN(TL)) u_seq_device (.hclk(hclk),
    .hresetn(hresetn), .bus(u_ctrl_if.dev), .ctl_reg0_view(reg1_view),
    .seq_busy(seq_busy), .sequence_done_event(done_ev));
  seq_props #(.TICK_LEN(TL)) u_seq_props (.hclk(hclk),
    .hresetn(hresetn), .wr_stb(u_ctrl_if.wr_stb),
    .rd_stb(u_ctrl_if.rd_stb), .addr(u_ctrl_if.addr),
    .wdata(u_ctrl_if.wdata), .rdata(u_ctrl_if.rdata),
    .rd_ack(u_ctrl_if.rd_ack), .busy(u_ctrl_if.busy));
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test
  task automatic expire();
    errors++;
    $display("mismatch %0t wait ran out", $time);
    finish_test();
  endtask : expire
  task automatic check(input logic [15:0] got, exp, input string m);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : check
  // One whole-word single transfer; every call waits a fresh edge
  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge hclk);
    htrans <= seq_pkg::HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    q = hrdata;
    if (n >= 50) expire();
  endtask : ahb
  task automatic dwr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] q;
    ahb(1'b1, seq_pkg::H_ADDR, {24'h0, a}, q);
    ahb(1'b1, seq_pkg::H_WDATA, {16'h0, d}, q);
  endtask : dwr
  task automatic drd(input logic [7:0] a, output logic [15:0] d);
    logic [31:0] q;
    int n;
    ahb(1'b1, seq_pkg::H_ADDR, {24'h0, a}, q);
    ahb(1'b1, seq_pkg::H_READ, 32'h0, q);
    n = 0;
    q = 32'h0;
    while (q[0] !== 1'b1) begin
      ahb(1'b0, seq_pkg::H_STATUS, 32'h0, q);
      n++;
      if (n > 20) expire();
    end
    ahb(1'b0, seq_pkg::H_RDATA, 32'h0, q);
    d = q[15:0];
  endtask : drd
  task automatic settle();
    repeat (3) @(negedge hclk);
  endtask : settle
  task automatic step(input logic [4:0] i, input logic [15:0] t, p);
    dwr(seq_pkg::REG_WRITE_PTR, {11'h0, i});
    dwr(seq_pkg::REG_TARGET, t);
    dwr(seq_pkg::REG_PAYLOAD, p);
  endtask : step
  // Launches and counts busy cycles, sampled mid-cycle
  task automatic run(input logic [15:0] lw, output int c);
    int n;
    dwr(seq_pkg::REG_LAUNCH, lw);
    n = 0;
    c = 0;
    while (seq_busy !== 1'b1 && n < 10) begin
      @(negedge hclk);
      n++;
    end
    while (seq_busy === 1'b1 && c < 20000) begin
      @(negedge hclk);
      c++;
    end
    if (seq_busy !== 1'b0) expire();
  endtask : run
  initial begin
    logic [15:0] r, m, e;
    logic [31:0] q;
    int c;
    errors = 0;
    tests_run = 0;
    hresetn = 1'b0;
    hsel = 1'b1;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    dwr(8'h7f, 16'h0001);
    run(seq_pkg::LAUNCH_STARTUP, c);
    check(16'((c + 2) / (9 * TL)), 16'd30, "startup steps");
    check(reg1_view, 16'h0, "dummy steps");
    drd(8'h7f, r);
    check(r, 16'h0001, "dummy target kept");
    drd(seq_pkg::REG_STATUS, r);
    check({10'h0, r[9:4]}, 16'h001d, "last index");
    check({15'h0, done_ev}, 16'h1, "done event");
    drd(seq_pkg::REG_LAUNCH, r);
    check({15'h0, r[8]}, 16'h0, "launch bit");
    dwr(seq_pkg::REG_EVENT, 16'h0001);
    settle();
    check({15'h0, done_ev}, 16'h0, "event clear");
    $display("test defaults ended");
    step(5'h05, 16'h3a01, 16'h0000);
    drd(seq_pkg::REG_TARGET, r);
    check(r, 16'h3a01, "target readback");
    drd(seq_pkg::REG_WRITE_PTR, r);
    check(r, 16'h0005, "pointer readback");
    $display("test program ended");
    for (int k = 0; k < 4; k++) begin
      dwr(8'h01, od[k]);
      step(5'd0, tg[k], {8'h40, dt[k]});
      run(seq_pkg::LAUNCH_STARTUP, c);
      m = ((16'h1 << ({1'b0, tg[k][14:12]} + 4'h1)) - 16'h1) << tg[k][11:8];
      e = (od[k] & ~m) | (({8'h0, dt[k]} << tg[k][11:8]) & m);
      check(reg1_view, e, "field write");
      check(16'((c + 2) / (9 * TL)), 16'd1, "one step");
    end
    $display("test fields ended");
    dwr(8'h01, 16'h0);
    step(5'd0, 16'h7002, 16'h0233);
    step(5'd1, 16'h7001, 16'h4077);
    run(seq_pkg::LAUNCH_STARTUP, c);
    check(16'((c + 2) / TL), 16'd21, "two step time");
    drd(8'h02, r);
    check(r, 16'h0033, "second register");
    check(reg1_view, 16'h0077, "first register");
    dwr(seq_pkg::REG_SW_RESET, 16'h0);
    settle();
    check(reg1_view, 16'h0, "soft reset");
    run(seq_pkg::LAUNCH_STARTUP, c);
    check(reg1_view, 16'h0077, "steps kept");
    $display("test sequence ended");
    run(seq_pkg::LAUNCH_SHUTDOWN, c);
    check(16'((c + 2) / (9 * TL)), 16'd17, "shutdown steps");
    drd(seq_pkg::REG_STATUS, r);
    check({10'h0, r[9:4]}, 16'h0030, "shutdown end");
    run(16'h0121, c);
    check(16'((c + 2) / (9 * TL)), 16'd16, "skip first");
    $display("test shutdown ended");
    dwr(8'h01, 16'h0);
    dwr(seq_pkg::REG_LAUNCH, seq_pkg::LAUNCH_SHUTDOWN);
    repeat (200) @(negedge hclk);
    drd(seq_pkg::REG_STATUS, r);
    check({15'h0, r[9:4] > 6'h20 && r[9:4] < 6'h30}, 16'h1, "progress");
    dwr(8'h01, 16'h1234);
    ahb(1'b0, seq_pkg::H_STATUS, 32'h0, q);
    check({15'h0, q[1]}, 16'h1, "write refused");
    check({15'h0, hresp}, 16'h0, "okay response");
    drd(8'h01, r);
    check(r, 16'h0, "locked read");
    dwr(seq_pkg::REG_LAUNCH, 16'h0200);
    settle();
    check({15'h0, seq_busy}, 16'h0, "abort");
    check(reg1_view, 16'h0, "refused write");
    $display("test locking ended");
    finish_test();
  end
endmodule : tb
`default_nettype wire
